// file: rtl/imgc_pkg.sv
// Shared constants and types of the two-wire master and general-call block
package imgc_pkg;

	// ----------------------------------------------------------------
	// Mode and address patterns
	// ----------------------------------------------------------------
	localparam logic [3:0] MASTER_MODE_CODE = 4'h8;
	localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Bit counts of one operation; transmit includes the acknowledge bit
	// ----------------------------------------------------------------
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] TX_BITS = 4'h9;
	localparam logic [3:0] RX_BITS = 4'h8;
	localparam logic [3:0] ACK_BITS = 4'h1;
	localparam logic [3:0] TX_LAST_DATA = 4'h2;
	localparam logic [3:0] COUNT_RESET = 4'h0;

	// ----------------------------------------------------------------
	// Baud generator phases and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] PHASE_RESET = 2'h0;
	localparam logic [1:0] PHASE_Q2 = 2'h1;
	localparam logic [1:0] PHASE_Q4 = 2'h3;
	localparam logic [6:0] BAUD_RESET = 7'h00;

	// ----------------------------------------------------------------
	// Master sequencer states and operation kinds
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		M_IDLE, M_START_WAIT, M_START_HOLD, M_RS_LOW, M_RS_RISE,
		M_BIT_LOW, M_BIT_RISE, M_BIT_HIGH,
		M_STOP_LOW, M_STOP_RISE, M_STOP_HIGH, M_STOP_END
	} imgc_state_t;

	typedef enum logic [1:0] {OP_TX, OP_RX, OP_ACK} imgc_op_t;

endpackage : imgc_pkg

// file: rtl/imgc_baud_if.sv
// Control and rollover signals between the sequencer and the baud generator
`timescale 1ns/1ps
`default_nettype none
interface imgc_baud_if;
	logic [6:0] reload;
	logic load;
	logic run;
	logic rollover;
	modport ctrl (output reload, output load, output run, input rollover);
	modport gen (input reload, input load, input run, output rollover);
endinterface : imgc_baud_if
`default_nettype wire

// file: rtl/imgc_sync.sv
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none
module imgc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset of the receiving domain
	input wire logic clock,
	input wire logic resetn,
	// Level in and synchronised level out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} imgc_sync_state_t;

	imgc_sync_state_t s;
	imgc_sync_state_t next_s;

	// First stage feeds only the second stage
	always_comb
	begin
		next_s.first = d;
		next_s.second = s.first;
	end

	// Register both stages
	always_ff @(posedge clock)
	begin
		if (!resetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign q = s.second;
endmodule : imgc_sync
`default_nettype wire

// file: rtl/imgc_baud.sv
// Down-counting baud generator, two decrements per four-phase cycle
`timescale 1ns/1ps
`default_nettype none
module imgc_baud
	import imgc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Sequencer side
	imgc_baud_if.gen bd
);
	typedef struct packed {
		logic [1:0] phase;
		logic [6:0] count;
		logic rollover;
	} imgc_baud_state_t;

	imgc_baud_state_t s;
	imgc_baud_state_t next_s;
	logic tick;

	// Load wins; a stopped generator holds its count until reloaded
	always_comb
	begin
		next_s = s;
		next_s.phase = s.phase + 2'h1;
		next_s.rollover = 1'b0;
		tick = (s.phase == PHASE_Q2) || (s.phase == PHASE_Q4);
		if (bd.load)
		begin
			next_s.count = bd.reload;
			next_s.phase = PHASE_RESET;
		end
		else if (bd.run && tick)
		begin
			if (s.count == BAUD_RESET)
			begin
				next_s.rollover = 1'b1;
				next_s.count = bd.reload; // Auto reload in master mode
			end
			else
				next_s.count = s.count - 7'h01;
		end
	end

	// State register
	always_ff @(posedge clock)
	begin
		if (!resetn)
			s <= '{phase: PHASE_RESET, count: BAUD_RESET, rollover: 1'b0};
		else
			s <= next_s;
	end

	assign bd.rollover = s.rollover;

	AST_BAUD_HOLD: assert property (@(posedge clock) disable iff (!resetn)
		(!bd.run && !bd.load) |=> (s.count == $past(s.count)) && !s.rollover)
		else $error("baud generator moved while stopped");
endmodule : imgc_baud
`default_nettype wire

// file: rtl/imgc_master.sv
// Two-wire serial module: master sequencer and general-call slave recognition
//
// Functional notes
// - General call is all zeros, write, when enabled
// - Shift eight bits, compare own and general call
// - Match: buffer loaded, full at eighth, flag ninth
// - Received address stays readable in data buffer
// - Ten-bit general call: no update flag, data next
// - Master runs when mode field and enable set
// - Start and stop flags clear on reset, disable
// - No queueing: early buffer write dropped, collision
// - Interrupt flag after every master event completes
// - Master makes clocks, start, stop; restart keeps bus
// - Transmit address with write, bytes, take acknowledge
// - Receive bytes after read address, send acknowledge
// - Record slave acknowledge, flag after ninth clock
// - Stop enable makes stop, flag when complete
// - Reload from low seven bits, write starts counting
// - Count down, halt, two ticks per cycle, reload
// - After acknowledge, clock stops, line keeps level
// - Serial clock period equals two generator rollovers
// - Released clock pauses generator until sampled high
// - Start: lines high, wait, pull data, wait, clear
// - Low line at start means collision and abort
`timescale 1ns/1ps
`default_nettype none
module imgc_master
	import imgc_pkg::*;
(
	// Clocks and reset
	input wire logic clock,
	input wire logic resetn,
	input wire logic linkClock,
	// Configuration
	input wire logic moduleEnable,
	input wire logic [3:0] modeSelectField,
	input wire logic generalCallEnable,
	input wire logic tenBitMode,
	input wire logic [7:0] ownAddressOrReload,
	// Software requests, one-cycle pulses
	input wire logic startRequest,
	input wire logic repeatStartRequest,
	input wire logic stopRequest,
	input wire logic receiveRequest,
	input wire logic ackRequest,
	input wire logic ackData,
	input wire logic bufferWrite,
	input wire logic [7:0] bufferWriteData,
	input wire logic bufferRead,
	input wire logic addressUpdate,
	input wire logic clearInterrupt,
	input wire logic clearWriteCollision,
	input wire logic clearBusCollision,
	// Status
	output logic [7:0] serialDataBuffer,
	output logic bufferFullFlag,
	output logic serialInterruptFlag,
	output logic writeCollisionFlag,
	output logic busCollisionFlag,
	output logic startDetected,
	output logic stopDetected,
	output logic startEnable,
	output logic stopEnable,
	output logic ackStatus,
	output logic updateAddressFlag,
	// Open-drain bus pins
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe
);
	// ----------------------------------------------------------------
	// State of both domains
	// ----------------------------------------------------------------
	typedef struct packed {
		imgc_state_t state;
		imgc_op_t op;
		logic [7:0] shifter;
		logic [3:0] bitsLeft;
		logic brgLoad;
		logic sclPull;
		logic sdaPull;
		logic pinLow;
		logic sclPrev;
		logic sdaPrev;
		logic byteSeen;
		logic ninthSeen;
		logic slaveAck;
		logic slaveFirst;
		logic slaveAddressed;
		logic [7:0] buffer;
		logic bufferFull;
		logic interrupt;
		logic writeCollision;
		logic busCollision;
		logic startDet;
		logic stopDet;
		logic startEn;
		logic stopEn;
		logic ackStat;
		logic updateAddr;
	} imgc_main_t;

	typedef struct packed {
		logic sclPrev;
		logic sdaPrev;
		logic active;
		logic [3:0] bitCount;
		logic [7:0] shift;
		logic [7:0] heldByte;
		logic byteToggle;
		logic ninthToggle;
		logic ackWindow;
	} imgc_link_t;

	imgc_main_t s;
	imgc_main_t next_s;
	imgc_link_t l;
	imgc_link_t next_l;
	logic [1:0] pinSync;
	logic [1:0] linkPins;
	logic [2:0] linkEvents;
	logic linkResetn;
	logic scl;
	logic sda;
	logic masterMode;
	logic rollover;
	logic busStart;
	logic busStop;
	logic byteEvent;
	logic ninthEvent;
	logic bitPull;
	logic gcHit;
	logic ownHit;
	logic tenHigh;
	logic linkRise;
	logic linkFall;

	imgc_baud_if bd ();

	// ----------------------------------------------------------------
	// Crossings and baud generator
	// ----------------------------------------------------------------
	imgc_sync #(.WIDTH(2)) u_pinSync (
		.clock(clock), .resetn(resetn), .d({sclIn, sdaIn}), .q(pinSync)
	);
	imgc_sync #(.WIDTH(1)) u_linkReset (
		.clock(linkClock), .resetn(resetn), .d(1'b1), .q(linkResetn)
	);
	imgc_sync #(.WIDTH(2)) u_linkPins (
		.clock(linkClock), .resetn(linkResetn), .d({sclIn, sdaIn}), .q(linkPins)
	);
	// Toggles carry byte events; the held byte is stable long before its toggle lands
	imgc_sync #(.WIDTH(3)) u_linkEvents (
		.clock(clock), .resetn(resetn),
		.d({l.ackWindow, l.ninthToggle, l.byteToggle}), .q(linkEvents)
	);
	imgc_baud u_baud (.clock(clock), .resetn(resetn), .bd(bd));

	assign scl = pinSync[1];
	assign sda = pinSync[0];
	assign bd.reload = ownAddressOrReload[6:0];
	assign bd.load = s.brgLoad;
	assign bd.run = (s.state != M_IDLE) && (s.state != M_BIT_RISE) &&
		(s.state != M_RS_RISE) && (s.state != M_STOP_RISE);

	// ----------------------------------------------------------------
	// Link domain: start detect and byte shifting for slave recognition
	// ----------------------------------------------------------------
	always_comb
	begin
		next_l = l;
		next_l.sclPrev = linkPins[1];
		next_l.sdaPrev = linkPins[0];
		linkRise = !l.sclPrev && linkPins[1];
		linkFall = l.sclPrev && !linkPins[1];
		if (l.sclPrev && linkPins[1] && l.sdaPrev && !linkPins[0])
		begin
			next_l.active = 1'b1;
			next_l.bitCount = COUNT_RESET;
			next_l.ackWindow = 1'b0;
		end
		else if (l.sclPrev && linkPins[1] && !l.sdaPrev && linkPins[0])
		begin
			next_l.active = 1'b0;
			next_l.ackWindow = 1'b0;
		end
		else if (l.active)
		begin
			if (linkRise && (l.bitCount < BYTE_BITS))
			begin
				next_l.shift = {l.shift[6:0], linkPins[0]};
				next_l.bitCount = l.bitCount + 4'h1;
				if (l.bitCount == (BYTE_BITS - 4'h1))
				begin
					next_l.heldByte = {l.shift[6:0], linkPins[0]};
					next_l.byteToggle = !l.byteToggle;
				end
			end
			if (linkFall && (l.bitCount == BYTE_BITS))
			begin
				if (!l.ackWindow)
					next_l.ackWindow = 1'b1;
				else
				begin
					next_l.ackWindow = 1'b0; // Falling edge of the ninth bit
					next_l.bitCount = COUNT_RESET;
					next_l.ninthToggle = !l.ninthToggle;
				end
			end
		end
	end

	// Link domain register
	always_ff @(posedge linkClock)
	begin
		if (!linkResetn)
			l <= '0;
		else
			l <= next_l;
	end

	// ----------------------------------------------------------------
	// Main domain: flags, slave recognition and master sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.brgLoad = 1'b0;
		next_s.pinLow = 1'b0; // Pins only ever drive low
		next_s.sclPrev = scl;
		next_s.sdaPrev = sda;
		next_s.byteSeen = linkEvents[0];
		next_s.ninthSeen = linkEvents[1];
		masterMode = moduleEnable && (modeSelectField == MASTER_MODE_CODE);
		rollover = bd.rollover && !s.brgLoad;
		busStart = s.sclPrev && scl && s.sdaPrev && !sda;
		busStop = s.sclPrev && scl && !s.sdaPrev && sda;
		byteEvent = linkEvents[0] != s.byteSeen;
		ninthEvent = linkEvents[1] != s.ninthSeen;
		bitPull = (s.op != OP_RX) && !s.shifter[7];
		gcHit = generalCallEnable && (l.heldByte == GENERAL_CALL_ADDR);
		ownHit = !tenBitMode && (l.heldByte[7:1] == ownAddressOrReload[7:1]);
		tenHigh = tenBitMode && (l.heldByte[7:3] == TEN_BIT_PREFIX) &&
			(l.heldByte[2:1] == ownAddressOrReload[2:1]);

		// Software clears come first so that a same-cycle hardware set wins
		if (clearInterrupt)
			next_s.interrupt = 1'b0;
		if (clearWriteCollision)
			next_s.writeCollision = 1'b0;
		if (clearBusCollision)
			next_s.busCollision = 1'b0;
		if (bufferRead)
			next_s.bufferFull = 1'b0;
		if (addressUpdate)
			next_s.updateAddr = 1'b0;

		// Bus conditions seen on the lines
		if (busStart)
		begin
			next_s.startDet = 1'b1;
			next_s.stopDet = 1'b0;
			next_s.slaveFirst = 1'b1;
			next_s.slaveAddressed = 1'b0;
		end
		else if (busStop)
		begin
			next_s.stopDet = 1'b1;
			next_s.startDet = 1'b0;
			next_s.slaveAddressed = 1'b0;
		end

		if (!masterMode)
		begin
			// Slave side: only the acknowledge is ever driven
			next_s.state = M_IDLE;
			next_s.sclPull = 1'b0;
			next_s.startEn = 1'b0;
			next_s.stopEn = 1'b0;
			next_s.sdaPull = linkEvents[2] && s.slaveAck;
			if (moduleEnable && byteEvent && s.slaveFirst)
			begin
				next_s.slaveFirst = 1'b0;
				next_s.slaveAddressed = gcHit || ownHit || tenHigh;
				next_s.slaveAck = (gcHit || ownHit || tenHigh) && !s.bufferFull;
				if (gcHit || ownHit || tenHigh)
				begin
					next_s.buffer = l.heldByte; // Address kept readable
					next_s.bufferFull = 1'b1;
					next_s.updateAddr = s.updateAddr || (tenHigh && !gcHit);
				end
			end
			else if (moduleEnable && byteEvent && s.slaveAddressed)
			begin
				next_s.buffer = l.heldByte;
				next_s.slaveAck = !s.bufferFull; // Overflow withholds acknowledge
				next_s.bufferFull = 1'b1;
			end
			if (moduleEnable && ninthEvent)
			begin
				next_s.slaveAck = 1'b0;
				if (s.slaveAddressed)
					next_s.interrupt = 1'b1;
			end
		end
		else
		begin
			// No queueing: a buffer write outside idle is dropped
			if (bufferWrite && (s.state != M_IDLE))
				next_s.writeCollision = 1'b1;
			unique case (s.state)
				M_IDLE:
				begin
					if (startRequest)
					begin
						if (!scl || !sda)
							next_s.busCollision = 1'b1;
						else
						begin
							next_s.startEn = 1'b1;
							next_s.state = M_START_WAIT;
							next_s.brgLoad = 1'b1;
						end
					end
					else if (repeatStartRequest)
					begin
						next_s.sclPull = 1'b1; // Bus kept through a restart
						next_s.state = M_RS_LOW;
						next_s.brgLoad = 1'b1;
					end
					else if (stopRequest)
					begin
						next_s.stopEn = 1'b1;
						next_s.sclPull = 1'b1;
						next_s.sdaPull = 1'b1;
						next_s.state = M_STOP_LOW;
						next_s.brgLoad = 1'b1;
					end
					else if (receiveRequest || ackRequest || bufferWrite)
					begin
						next_s.sclPull = 1'b1;
						next_s.state = M_BIT_LOW;
						next_s.brgLoad = 1'b1; // Write starts the generator
						if (receiveRequest)
						begin
							next_s.op = OP_RX;
							next_s.bitsLeft = RX_BITS;
						end
						else if (ackRequest)
						begin
							next_s.op = OP_ACK;
							next_s.bitsLeft = ACK_BITS;
							next_s.shifter = {ackData, 7'h7f};
						end
						else
						begin
							next_s.op = OP_TX; // Address byte carries its own R/W bit
							next_s.bitsLeft = TX_BITS;
							next_s.shifter = bufferWriteData;
							next_s.buffer = bufferWriteData;
							next_s.bufferFull = 1'b1;
						end
					end
				end
				M_START_WAIT:
				begin
					if (!scl)
					begin
						next_s.busCollision = 1'b1; // Clock dropped early
						next_s.startEn = 1'b0;
						next_s.sdaPull = 1'b0;
						next_s.state = M_IDLE;
					end
					else if (rollover)
					begin
						if (!sda)
						begin
							next_s.busCollision = 1'b1;
							next_s.startEn = 1'b0;
							next_s.state = M_IDLE;
						end
						else
						begin
							next_s.sdaPull = 1'b1; // Data low while clock high
							next_s.startDet = 1'b1;
							next_s.stopDet = 1'b0;
							next_s.state = M_START_HOLD;
							next_s.brgLoad = 1'b1;
						end
					end
				end
				M_START_HOLD:
				begin
					if (rollover)
					begin
						next_s.startEn = 1'b0;
						next_s.interrupt = 1'b1;
						next_s.state = M_IDLE;
					end
				end
				M_RS_LOW:
				begin
					next_s.sdaPull = 1'b0;
					if (rollover)
					begin
						next_s.sclPull = 1'b0;
						next_s.state = M_RS_RISE;
					end
				end
				M_RS_RISE, M_BIT_RISE, M_STOP_RISE:
				begin
					// Generator waits for the line itself to go high
					if (scl)
					begin
						next_s.brgLoad = 1'b1;
						next_s.state = (s.state == M_RS_RISE) ? M_START_WAIT :
							(s.state == M_BIT_RISE) ? M_BIT_HIGH : M_STOP_HIGH;
					end
				end
				M_BIT_LOW:
				begin
					// Data moves one cycle after the clock falls, giving hold time
					if (s.brgLoad)
						next_s.sdaPull = bitPull;
					if (rollover)
					begin
						next_s.sclPull = 1'b0; // Low then high, two rollovers a period
						next_s.state = M_BIT_RISE;
					end
				end
				M_BIT_HIGH:
				begin
					if (rollover)
					begin
						next_s.sclPull = 1'b1;
						next_s.bitsLeft = s.bitsLeft - 4'h1;
						next_s.shifter = {s.shifter[6:0], (s.op == OP_RX) ? sda : 1'b1};
						if ((s.op == OP_TX) && (s.bitsLeft == TX_LAST_DATA))
							next_s.bufferFull = 1'b0;
						if ((s.op == OP_TX) && (s.bitsLeft == ACK_BITS))
							next_s.ackStat = sda;
						if (s.bitsLeft == ACK_BITS)
						begin
							next_s.state = M_IDLE; // Clock stays low until next request
							next_s.interrupt = 1'b1;
							if (s.op == OP_RX)
							begin
								next_s.buffer = {s.shifter[6:0], sda};
								next_s.bufferFull = 1'b1;
							end
						end
						else
						begin
							next_s.state = M_BIT_LOW;
							next_s.brgLoad = 1'b1;
						end
					end
				end
				M_STOP_LOW:
				begin
					if (rollover)
					begin
						next_s.sclPull = 1'b0;
						next_s.state = M_STOP_RISE;
					end
				end
				M_STOP_HIGH:
				begin
					if (rollover)
					begin
						next_s.sdaPull = 1'b0; // Data rises while clock high
						next_s.state = M_STOP_END;
						next_s.brgLoad = 1'b1;
					end
				end
				M_STOP_END:
				begin
					if (rollover)
					begin
						next_s.stopEn = 1'b0;
						next_s.interrupt = 1'b1;
						next_s.state = M_IDLE;
					end
				end
			endcase
		end

		// Disable clears bus status
		if (!moduleEnable)
		begin
			next_s.startDet = 1'b0;
			next_s.stopDet = 1'b0;
			next_s.slaveFirst = 1'b0;
			next_s.slaveAddressed = 1'b0;
			next_s.sdaPull = 1'b0;
		end
	end

	// Main domain register; reset clears the bus status too
	always_ff @(posedge clock)
	begin
		if (!resetn)
			s <= '{state: M_IDLE, op: OP_TX, shifter: BYTE_RESET, bitsLeft: COUNT_RESET,
				buffer: BYTE_RESET, default: 1'b0};
		else
			s <= next_s;
	end

	// ----------------------------------------------------------------
	// Outputs, all from flops
	// ----------------------------------------------------------------
	assign serialDataBuffer = s.buffer;
	assign bufferFullFlag = s.bufferFull;
	assign serialInterruptFlag = s.interrupt;
	assign writeCollisionFlag = s.writeCollision;
	assign busCollisionFlag = s.busCollision;
	assign startDetected = s.startDet;
	assign stopDetected = s.stopDet;
	assign startEnable = s.startEn;
	assign stopEnable = s.stopEn;
	assign ackStatus = s.ackStat;
	assign updateAddressFlag = s.updateAddr;
	assign sclOut = s.pinLow;
	assign sclOe = s.sclPull;
	assign sdaOut = s.pinLow;
	assign sdaOe = s.sdaPull;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_OPEN_DRAIN: assert property (@(posedge clock) disable iff (!resetn)
		!masterMode |=> !sclOe && !sclOut && !sdaOut)
		else $error("pin driven high or clock pulled in slave mode");
	AST_DISABLE_CLEARS: assert property (@(posedge clock) disable iff (!resetn)
		!moduleEnable |=> !startDetected && !stopDetected)
		else $error("bus status survived disable");
	AST_WRITE_COLLISION_FLAG: assert property (@(posedge clock) disable iff (!resetn)
		masterMode && (s.state != M_IDLE) && bufferWrite
		|=> writeCollisionFlag && (serialDataBuffer == $past(serialDataBuffer)))
		else $error("queued buffer write not refused");
	AST_START_COLLISION: assert property (@(posedge clock) disable iff (!resetn)
		masterMode && (s.state == M_IDLE) && startRequest && (!scl || !sda)
		|=> busCollisionFlag && (s.state == M_IDLE) && !startEnable)
		else $error("start on busy lines not aborted");
	AST_START_DONE: assert property (@(posedge clock) disable iff (!resetn)
		masterMode && (s.state == M_START_HOLD) && rollover
		|=> !startEnable && serialInterruptFlag && sdaOe && (s.state == M_IDLE))
		else $error("start completion wrong");
	AST_ARBITRATION: assert property (@(posedge clock) disable iff (!resetn)
		masterMode && (s.state == M_BIT_RISE) && !scl |=> (s.state == M_BIT_RISE) && !sclOe)
		else $error("clock high phase began before line was high");
	AST_TX_ACK: assert property (@(posedge clock) disable iff (!resetn)
		masterMode && (s.state == M_BIT_HIGH) && (s.op == OP_TX) &&
		(s.bitsLeft == ACK_BITS) && rollover
		|=> serialInterruptFlag && (ackStatus == $past(sda)) && sclOe && (s.state == M_IDLE))
		else $error("acknowledge not recorded at ninth clock");
	AST_GC_MATCH: assert property (@(posedge clock) disable iff (!resetn)
		!masterMode && moduleEnable && byteEvent && s.slaveFirst && gcHit
		|=> bufferFullFlag && (serialDataBuffer == GENERAL_CALL_ADDR) &&
			(!updateAddressFlag || $past(updateAddressFlag)))
		else $error("general call not recognised");
	AST_LINK_NINTH: assert property (@(posedge linkClock) disable iff (!linkResetn)
		l.active && linkFall && l.ackWindow && (l.bitCount == BYTE_BITS) &&
		!(l.sclPrev && linkPins[1])
		|=> (l.bitCount == COUNT_RESET) && (l.ninthToggle != $past(l.ninthToggle)))
		else $error("ninth bit falling edge missed");
endmodule : imgc_master
`default_nettype wire

// file: tb/imgc_slave_model.sv
// Behavioural slave on the two-wire bus that acknowledges its address and data
`timescale 1ns/1ps
`default_nettype none
module imgc_slave_model #(
	parameter logic [6:0] ADDR = 7'h50
) (
	// Bus levels in, data pull-down out
	input wire logic scl,
	input wire logic sda,
	output logic ackOe,
	output logic [7:0] lastByte
);
	// ------------------------------------------------------------
	// Framing, sampling and acknowledge
	// ------------------------------------------------------------
	int bitCnt = 15;
	logic first = 1'b0, sel = 1'b0;
	logic [7:0] sh = 8'h00;
	initial ackOe = 1'b0;
	initial lastByte = 8'h00;
	// Start restarts the count; a stop parks it out of range
	always @(negedge sda)
		if (scl)
		begin
			bitCnt = 0;
			first = 1'b1;
		end
	always @(posedge sda)
		if (scl)
			bitCnt = 15;
	// Data is sampled while the clock is high
	always @(posedge scl)
	begin
		if (bitCnt < 8)
			sh = {sh[6:0], sda};
		bitCnt = bitCnt + 1;
	end
	// Acknowledge only a matching address, every data byte after it
	always @(negedge scl)
	begin
		if (bitCnt == 8)
		begin
			lastByte = sh;
			if (first)
				sel = sh[7:1] == ADDR;
			ackOe = sel;
		end
		else if (bitCnt == 9)
		begin
			ackOe = 1'b0;
			bitCnt = 0;
			first = 1'b0;
		end
	end
endmodule : imgc_slave_model
`default_nettype wire

// file: tb/tb_i2c_master_and_general_call.sv
// Self-checking bench of the two-wire master and general-call block
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_master_and_general_call
	import imgc_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus, bus wiring and checks
	// ------------------------------------------------------------
	logic clock = 1'b0, linkClock = 1'b0, resetn = 1'b0, moduleEnable = 1'b0;
	logic [3:0] modeSelectField = 4'h0;
	logic generalCallEnable = 1'b1, tenBitMode = 1'b1, tbScl = 1'b1, tbSda = 1'b1;
	logic [7:0] ownAddressOrReload = 8'hf0, bufferWriteData = 8'h00;
	logic startRequest = 1'b0, repeatStartRequest = 1'b0, stopRequest = 1'b0;
	logic receiveRequest = 1'b0, ackRequest = 1'b0, busCollisionFlag, stopEnable;
	logic bufferWrite = 1'b0, bufferRead = 1'b0, clearInterrupt = 1'b0, clearWc = 1'b0;
	logic [7:0] serialDataBuffer, lastByte;
	logic bufferFullFlag, serialInterruptFlag, writeCollisionFlag, startDetected;
	logic stopDetected, startEnable, ackStatus, updateAddressFlag, sclOe, sdaOe, ackOe;
	// Open-drain lines: low if anyone pulls, else the pull-up
	wire scl = tbScl & !sclOe;
	wire sda = tbSda & !sdaOe & !ackOe;
	int fails = 0, n_compared = 0;
	initial forever #20 clock = !clock;
	initial forever #7.5 linkClock = !linkClock;
	imgc_master dut (.clock, .resetn, .linkClock, .moduleEnable, .modeSelectField,
		.generalCallEnable, .tenBitMode, .ownAddressOrReload, .startRequest,
		.repeatStartRequest, .stopRequest, .receiveRequest, .ackRequest,
		.ackData(1'b0), .bufferWrite, .bufferWriteData, .bufferRead, .addressUpdate(1'b0),
		.clearInterrupt, .clearWriteCollision(clearWc), .clearBusCollision(1'b0),
		.serialDataBuffer, .bufferFullFlag, .serialInterruptFlag, .writeCollisionFlag,
		.busCollisionFlag, .startDetected, .stopDetected, .startEnable, .stopEnable,
		.ackStatus, .updateAddressFlag, .sclIn(scl), .sclOut(), .sclOe, .sdaIn(sda),
		.sdaOut(), .sdaOe);
	imgc_slave_model slave (.scl(scl), .sda(sda), .ackOe(ackOe), .lastByte(lastByte));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask : chk
	// Half a bit of the bench-driven bus, slow against the pin synchronisers
	task automatic half();
		repeat (20) @(negedge clock);
	endtask : half
	// Bounded wait for the interrupt, then clear the interrupt, write collision and buffer full flags
	task automatic waitf();
		for (int i = 0; i < 3000 && serialInterruptFlag !== 1'b1; i++)
			@(negedge clock);
		chk(serialInterruptFlag, 1'b1, "no interrupt");
		{clearInterrupt, bufferRead, clearWc} = 3'b111;
		@(negedge clock);
		{clearInterrupt, bufferRead, clearWc} = 3'b000;
		@(negedge clock);
	endtask : waitf
	task automatic send(input logic [7:0] data, input logic nack);
		bufferWriteData = data;
		bufferWrite = 1'b1;
		@(negedge clock);
		bufferWrite = 1'b0;
		waitf();
		chk({ackStatus, sclOe}, {nack, 1'b1}, "ack status");
		chk(lastByte, data, "byte on wire");
	endtask : send
	// Bench masters a general call into the block in ten-bit slave mode
	task automatic t_gc();
		tbSda = 1'b0;
		half();
		for (int b = 0; b < 9; b++)
		begin
			tbScl = 1'b0;
			tbSda = (b == 8);
			half();
			tbScl = 1'b1;
			half();
		end
		chk(sda, 1'b0, "gc not acked");
		chk({serialDataBuffer, bufferFullFlag}, {GENERAL_CALL_ADDR, 1'b1}, "gc buf");
		chk(serialInterruptFlag, 1'b0, "early flag");
		tbScl = 1'b0;
		half();
		chk(updateAddressFlag, 1'b0, "gc update flag");
		waitf();
		tbSda = 1'b0;
		half();
		tbScl = 1'b1;
		half();
		tbSda = 1'b1;
		half();
	endtask : t_gc
	// Start with a queued write, address, data, restart, refused address, stop
	task automatic t_master();
		modeSelectField = MASTER_MODE_CODE;
		ownAddressOrReload = 8'h02;
		tbScl = 1'b0;
		repeat (3) @(negedge clock);
		startRequest = 1'b1;
		@(negedge clock);
		{startRequest, tbScl} = 2'b01;
		@(negedge clock);
		chk({busCollisionFlag, startEnable, stopDetected}, 3'b101, "collision");
		repeat (4) @(negedge clock);
		startRequest = 1'b1;
		@(negedge clock);
		{startRequest, bufferWrite, bufferWriteData} = {2'b01, 8'h5a};
		@(negedge clock);
		bufferWrite = 1'b0;
		@(negedge clock);
		chk({writeCollisionFlag, startEnable}, 2'b11, "queued write");
		chk(serialDataBuffer, GENERAL_CALL_ADDR, "buffer kept");
		waitf();
		chk({startDetected, startEnable, scl, sda}, 4'b1010, "start");
		send(8'ha0, 1'b0);
		send(8'h3c, 1'b0);
		repeatStartRequest = 1'b1;
		@(negedge clock);
		repeatStartRequest = 1'b0;
		waitf();
		send(8'hb1, 1'b1);
		{receiveRequest, tbSda} = 2'b10;
		@(negedge clock);
		receiveRequest = 1'b0;
		waitf();
		tbSda = 1'b1;
		chk(serialDataBuffer, 8'h00, "rx byte");
		ackRequest = 1'b1;
		@(negedge clock);
		ackRequest = 1'b0;
		waitf();
		chk({sdaOe, sclOe}, 2'b11, "ack sent");
		stopRequest = 1'b1;
		@(negedge clock);
		stopRequest = 1'b0;
		chk(stopEnable, 1'b1, "stop enable");
		waitf();
		chk({stopEnable, stopDetected, scl, sda}, 4'b0111, "stop");
		moduleEnable = 1'b0;
		repeat (3) @(negedge clock);
		chk({startDetected, stopDetected}, 2'b00, "disable");
	endtask : t_master
	task automatic print_verdict();
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	initial
	begin
		repeat (8) @(negedge clock);
		resetn = 1'b1;
		repeat (3) @(negedge clock);
		chk({startDetected, stopDetected}, 2'b00, "reset");
		moduleEnable = 1'b1;
		t_gc();
		t_master();
		print_verdict();
	end
	initial
	begin
		#1000000;
		fails++;
		print_verdict();
	end
endmodule : tb_i2c_master_and_general_call
`default_nettype wire
